// file: crsc_params.svh
// offsets, field positions, reset values and timing counts of the clock and reset control block
`ifndef CRSC_PARAMS_SVH
`define CRSC_PARAMS_SVH
// register byte offsets
`define CRSC_OFF_RST_EN      4'h0
`define CRSC_OFF_CLK_SEL     4'h4
`define CRSC_OFF_RST_CAUSE   4'h8
`define CRSC_OFF_SW_RESET    4'hC
`define CRSC_OFF_IRQ_STATUS  5'h10
`define CRSC_OFF_IRQ_CLEAR   5'h14
`define CRSC_OFF_IRQ_ENABLE  5'h18
`define CRSC_OFF_CLK_STATUS  5'h1C
// reset cause bit positions
`define CRSC_SRC_POR         0
`define CRSC_SRC_SUPPLY      1
`define CRSC_SRC_USB         2
`define CRSC_SRC_WDOG        3
`define CRSC_SRC_MISSCLK     4
`define CRSC_SRC_CMP         5
`define CRSC_SRC_SOFT        6
`define CRSC_SRC_PIN         7
`define CRSC_SRC_FLASH       8
`define CRSC_NUM_SRC         9
// reset enable register: maskable sources only, bit 9 locks the watchdog on
`define CRSC_RST_EN_RESET    9'h000
`define CRSC_RST_EN_MASKABLE 9'h07E
`define CRSC_WDOG_LOCK_BIT   9
// clock select register fields
`define CRSC_SYS_SEL_LSB     0
`define CRSC_MUL_SRC_BIT     2
`define CRSC_MUL_EN_BIT      3
`define CRSC_USB_SEL_BIT     4
`define CRSC_REC_EN_BIT      5
`define CRSC_CLK_SEL_RESET   6'h00
// interrupt event bits
`define CRSC_EV_CLK_SWITCHED 0
`define CRSC_EV_RST_SEEN     1
`define CRSC_NUM_EV          2
// internal reset stretch after all requests end
`define CRSC_RST_HOLD_NS     64
`define CRSC_CLK_PERIOD_NS   4
`define CRSC_RST_HOLD_CYC    ((`CRSC_RST_HOLD_NS + `CRSC_CLK_PERIOD_NS - 1) / `CRSC_CLK_PERIOD_NS)
`endif

// file: crsc_pkg.sv
// types of the clock and reset control block
package crsc_pkg;
    typedef enum logic [1:0] {
        CRSC_SYS_HFOSC,
        CRSC_SYS_LFOSC,
        CRSC_SYS_EXTOSC,
        CRSC_SYS_MUL_DIV2
    } crsc_sys_src_e;
    typedef enum logic [1:0] {
        CRSC_SW_IDLE,
        CRSC_SW_WAIT_OLD,
        CRSC_SW_WAIT_NEW
    } crsc_sw_state_e;
endpackage

// file: crsc_sync.sv
// two-flop level synchroniser, one per bit
`timescale 1ns/100ps
`default_nettype none
module crsc_sync #(
    parameter int WIDTH = 1
) (
    // clock and reset
    input wire logic clk_in,
    input wire logic reset_n_in,
    // data
    input wire logic [WIDTH-1:0] async_in,
    output logic [WIDTH-1:0] sync_out
);
    logic [WIDTH-1:0] meta_ff;
    logic [WIDTH-1:0] sync_ff;
    genvar i;
    generate
        for (i = 0; i < WIDTH; i = i + 1) begin : g_bit
            always_ff @(posedge clk_in or negedge reset_n_in) begin
                if (!reset_n_in) begin
                    meta_ff[i] <= 1'b0;
                    sync_ff[i] <= 1'b0;
                end else begin
                    meta_ff[i] <= async_in[i];
                    sync_ff[i] <= meta_ff[i];
                end
            end
        end
    endgenerate
    assign sync_out = sync_ff;
endmodule
`default_nettype wire

// file: crsc_top.sv
// clock source selection and reset combining, with avalon-mm registers
//
// Functional notes
// - nine reset causes feed one combiner
// - all but por, pin, flash maskable
// - watchdog lock holds until power-on reset
// - enabled supply low holds device reset
// - system clock: hf, lf, external, multiplier/2
// - clock source changes at run time
// - usb clock from 4x multiplier, recovery on
// - usb clock from internal oscillator directly
// - multiplier input selectable from external oscillator
// - cpu and usb selects are independent
// - debug halt stalls peripherals except usb/adc/smbus
`include "crsc_params.svh"
`timescale 1ns/100ps
`default_nettype none
module crsc_top
    import crsc_pkg::*;
#(
    parameter int NUM_PERIPH = 8,
    parameter int HOLD_CYC = `CRSC_RST_HOLD_CYC
) (
    // clock and power-on reset
    input wire logic clk_in,
    input wire logic reset_n_in,
    // avalon-mm slave
    input wire logic [4:0] avs_address_in,
    input wire logic avs_read_in,
    input wire logic avs_write_in,
    input wire logic [31:0] avs_writedata_in,
    output logic [31:0] avs_readdata_out,
    output logic avs_waitrequest_out,
    // asynchronous reset requests
    input wire logic supply_low_in,
    input wire logic usb_bus_event_in,
    input wire logic watchdog_timer_expired_in,
    input wire logic missing_clock_in,
    input wire logic comparator_level_in,
    input wire logic ext_reset_pin_n_in,
    input wire logic flash_violation_in,
    // oscillator levels sampled for the switch handshake
    input wire logic hf_osc_level_in,
    input wire logic lf_osc_level_in,
    input wire logic ext_osc_level_in,
    input wire logic mul_div2_level_in,
    // debug halt from the two_wire_debug_link
    input wire logic debug_halt_in,
    // peripheral stall, bit set means usb, adc or smbus
    input wire logic [NUM_PERIPH-1:0] periph_exempt_in,
    output logic [NUM_PERIPH-1:0] periph_stall_out,
    // clock controls
    output logic [1:0] sys_clk_sel_out,
    output logic sys_clk_gate_out,
    output logic mul_src_ext_out,
    output logic mul_enable_out,
    output logic usb_clk_from_mul_out,
    output logic clock_recovery_out,
    // resets and interrupt
    output logic sys_reset_n_out,
    output logic irq_out
);
    // ------------------------------------------------------------
    // synchronisers
    // ------------------------------------------------------------
    logic [6:0] req_raw;
    logic [6:0] req_sync;
    logic [3:0] osc_sync;
    logic halt_sync;
    assign req_raw = {flash_violation_in, ~ext_reset_pin_n_in, comparator_level_in, missing_clock_in,
                      watchdog_timer_expired_in, usb_bus_event_in, supply_low_in};
    crsc_sync #(.WIDTH(12)) u_sync (
        .clk_in(clk_in),
        .reset_n_in(reset_n_in),
        .async_in({debug_halt_in, mul_div2_level_in, ext_osc_level_in, lf_osc_level_in, hf_osc_level_in,
                   req_raw}),
        .sync_out({halt_sync, osc_sync, req_sync})
    );
    // ------------------------------------------------------------
    // registers
    // ------------------------------------------------------------
    logic [9:0] rst_en_ff;
    logic [5:0] clk_sel_ff;
    logic [`CRSC_NUM_SRC-1:0] cause_ff;
    logic [`CRSC_NUM_EV-1:0] irq_stat_ff;
    logic [`CRSC_NUM_EV-1:0] irq_en_ff;
    logic soft_req_ff;
    logic rd_valid_ff;
    logic wr_rst_en;
    logic wr_clk_sel;
    logic wr_soft;
    logic wr_irq_clr;
    logic wr_irq_en;
    // reads pay one wait state so that read data leave a flop; writes never wait
    assign avs_waitrequest_out = avs_read_in && !rd_valid_ff;
    assign wr_rst_en = avs_write_in && (avs_address_in == 5'(`CRSC_OFF_RST_EN));
    assign wr_clk_sel = avs_write_in && (avs_address_in == 5'(`CRSC_OFF_CLK_SEL));
    // a software request written while disabled is dropped, so a later enable cannot fire it
    assign wr_soft = avs_write_in && (avs_address_in == 5'(`CRSC_OFF_SW_RESET)) && avs_writedata_in[0]
                     && rst_en_ff[`CRSC_SRC_SOFT];
    assign wr_irq_clr = avs_write_in && (avs_address_in == `CRSC_OFF_IRQ_CLEAR);
    assign wr_irq_en = avs_write_in && (avs_address_in == `CRSC_OFF_IRQ_ENABLE);
    // ------------------------------------------------------------
    // reset combiner
    // ------------------------------------------------------------
    logic [`CRSC_NUM_SRC-1:0] req_vec;
    logic [`CRSC_NUM_SRC-1:0] gate_vec;
    logic any_req;
    logic [7:0] hold_cnt_ff;
    logic sys_rst_ff;
    assign req_vec = {req_sync[6], req_sync[5], soft_req_ff, req_sync[4], req_sync[3], req_sync[2],
                      req_sync[1], req_sync[0], 1'b0};
    // por, pin and flash bypass enables
    // the lock forces the watchdog in whatever its enable bit says
    assign gate_vec = rst_en_ff[8:0] | ~9'(`CRSC_RST_EN_MASKABLE)
                      | (9'(rst_en_ff[`CRSC_WDOG_LOCK_BIT]) << `CRSC_SRC_WDOG);
    // supply low held for its whole duration
    assign any_req = |(req_vec & gate_vec);
    // stretch reset after requests end
    // any new request restarts the count, so the stretch always follows the last one
    always_ff @(posedge clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            hold_cnt_ff <= 8'h00;
            sys_rst_ff <= 1'b1;
        end else if (any_req) begin
            hold_cnt_ff <= 8'h00;
            sys_rst_ff <= 1'b1;
        end else if (hold_cnt_ff < 8'(HOLD_CYC)) begin
            hold_cnt_ff <= hold_cnt_ff + 8'h01;
            sys_rst_ff <= 1'b1;
        end else begin
            sys_rst_ff <= 1'b0;
        end
    end
    assign sys_reset_n_out = ~sys_rst_ff;
    // cause register: latched on entry to reset, por after power-up
    always_ff @(posedge clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            cause_ff <= 9'(1) << `CRSC_SRC_POR;
        end else if (any_req && !sys_rst_ff) begin
            cause_ff <= req_vec & gate_vec;
        end
    end
    // ------------------------------------------------------------
    // control registers, reset only by power-on; the software request also clears when the internal reset asserts
    // ------------------------------------------------------------
    always_ff @(posedge clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            rst_en_ff <= {1'b0, 9'(`CRSC_RST_EN_RESET)};
        end else if (wr_rst_en) begin
            rst_en_ff[8:0] <= avs_writedata_in[8:0] & 9'(`CRSC_RST_EN_MASKABLE);
            rst_en_ff[`CRSC_WDOG_LOCK_BIT] <= rst_en_ff[`CRSC_WDOG_LOCK_BIT]
                                           | avs_writedata_in[`CRSC_WDOG_LOCK_BIT];
        end
    end
    // usb and cpu fields written together, all six bits by each write
    always_ff @(posedge clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            clk_sel_ff <= `CRSC_CLK_SEL_RESET;
        end else if (wr_clk_sel) begin
            clk_sel_ff <= avs_writedata_in[5:0];
        end
    end
    // software reset request stays until the internal reset asserts
    always_ff @(posedge clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            soft_req_ff <= 1'b0;
        end else if (wr_soft) begin
            soft_req_ff <= 1'b1;
        end else if (sys_rst_ff) begin
            soft_req_ff <= 1'b0;
        end
    end
    // ------------------------------------------------------------
    // usb and multiplier controls
    // ------------------------------------------------------------
    // multiplier input choice
    assign mul_src_ext_out = clk_sel_ff[`CRSC_MUL_SRC_BIT];
    assign mul_enable_out = clk_sel_ff[`CRSC_MUL_EN_BIT];
    // full speed via multiplier with recovery
    assign usb_clk_from_mul_out = clk_sel_ff[`CRSC_USB_SEL_BIT];
    assign clock_recovery_out = clk_sel_ff[`CRSC_REC_EN_BIT];
    // ------------------------------------------------------------
    // glitch-free system clock switch
    // ------------------------------------------------------------
    crsc_sw_state_e sw_state_ff;
    logic [1:0] cur_sel_ff;
    logic gate_ff;
    logic switched_pulse;
    crsc_sys_src_e req_sel;
    assign req_sel = crsc_sys_src_e'(clk_sel_ff[`CRSC_SYS_SEL_LSB +: 2]);
    // levels come through the synchroniser two cycles late; slow sources keep the
    // gate shut for longer, traded for keeping the switch in a single clock domain
    // four sources, old low then new low
    always_ff @(posedge clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            sw_state_ff <= CRSC_SW_IDLE;
            cur_sel_ff <= 2'h0;
            gate_ff <= 1'b1;
        end else begin
            case (sw_state_ff)
                CRSC_SW_IDLE: begin
                    if (req_sel != crsc_sys_src_e'(cur_sel_ff)) begin
                        sw_state_ff <= CRSC_SW_WAIT_OLD;
                    end
                end
                CRSC_SW_WAIT_OLD: begin
                    if (!osc_sync[cur_sel_ff]) begin
                        gate_ff <= 1'b0;
                        cur_sel_ff <= req_sel;
                        sw_state_ff <= CRSC_SW_WAIT_NEW;
                    end
                end
                CRSC_SW_WAIT_NEW: begin
                    if (!osc_sync[cur_sel_ff]) begin
                        gate_ff <= 1'b1;
                        sw_state_ff <= CRSC_SW_IDLE;
                    end
                end
                default: begin
                    sw_state_ff <= CRSC_SW_IDLE;
                end
            endcase
        end
    end
    assign switched_pulse = (sw_state_ff == CRSC_SW_WAIT_NEW) && !osc_sync[cur_sel_ff];
    assign sys_clk_sel_out = cur_sel_ff;
    assign sys_clk_gate_out = gate_ff;
    // ------------------------------------------------------------
    // debug stall
    // ------------------------------------------------------------
    // stall all but exempt peripherals
    assign periph_stall_out = {NUM_PERIPH{halt_sync}} & ~periph_exempt_in;
    // ------------------------------------------------------------
    // interrupts
    // ------------------------------------------------------------
    logic [`CRSC_NUM_EV-1:0] ev_vec;
    logic rst_seen_ff;
    always_ff @(posedge clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            rst_seen_ff <= 1'b0;
        end else begin
            rst_seen_ff <= sys_rst_ff;
        end
    end
    assign ev_vec = {rst_seen_ff && !sys_rst_ff, switched_pulse};
    // set wins over a clear in the same cycle
    always_ff @(posedge clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            irq_stat_ff <= 2'h0;
        end else begin
            irq_stat_ff <= (irq_stat_ff & ~(wr_irq_clr ? avs_writedata_in[1:0] : 2'h0)) | ev_vec;
        end
    end
    always_ff @(posedge clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            irq_en_ff <= 2'h0;
        end else if (wr_irq_en) begin
            irq_en_ff <= avs_writedata_in[1:0];
        end
    end
    assign irq_out = |(irq_stat_ff & irq_en_ff);
    // ------------------------------------------------------------
    // read data, registered; unmapped reads return zero
    // ------------------------------------------------------------
    logic [31:0] nxt_rdata;
    logic [31:0] rdata_ff;
    always_comb begin
        nxt_rdata = 32'h0000_0000;
        case (avs_address_in)
            5'(`CRSC_OFF_RST_EN): nxt_rdata = {22'h0, rst_en_ff};
            5'(`CRSC_OFF_CLK_SEL): nxt_rdata = {26'h0, clk_sel_ff};
            5'(`CRSC_OFF_RST_CAUSE): nxt_rdata = {23'h0, cause_ff};
            `CRSC_OFF_IRQ_STATUS: nxt_rdata = {30'h0, irq_stat_ff};
            `CRSC_OFF_IRQ_ENABLE: nxt_rdata = {30'h0, irq_en_ff};
            `CRSC_OFF_CLK_STATUS: nxt_rdata = {27'h0, halt_sync, sw_state_ff != CRSC_SW_IDLE, cur_sel_ff, gate_ff};
            default: nxt_rdata = 32'h0000_0000;
        endcase
    end
    always_ff @(posedge clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            rdata_ff <= 32'h0000_0000;
        end else if (avs_read_in && !rd_valid_ff) begin
            rdata_ff <= nxt_rdata;
        end
    end
    // the wait state lasts one cycle, so back-to-back reads each take two
    always_ff @(posedge clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            rd_valid_ff <= 1'b0;
        end else begin
            rd_valid_ff <= avs_read_in && !rd_valid_ff;
        end
    end
    assign avs_readdata_out = rdata_ff;
endmodule
`default_nettype wire

// file: crsc_top_properties.sv
// port assertions for the clock and reset control block
`timescale 1ns/100ps
`default_nettype none
module crsc_top_properties #(
    parameter int NUM_PERIPH = 8
) (
    // clock and reset
    input wire logic clk_in,
    input wire logic reset_n_in,
    // reset requests and result
    input wire logic ext_reset_pin_n_in,
    input wire logic flash_violation_in,
    input wire logic sys_reset_n_out,
    // debug stall
    input wire logic debug_halt_in,
    input wire logic [NUM_PERIPH-1:0] periph_exempt_in,
    input wire logic [NUM_PERIPH-1:0] periph_stall_out,
    // clock selection
    input wire logic [1:0] sys_clk_sel_out,
    input wire logic sys_clk_gate_out
);
    default clocking @(posedge clk_in); endclocking
    default disable iff (!reset_n_in);
    // ------------------------------------------
    // resets: two sync edges, then one flop
    // ------------------------------------------
    pin_reset_a: assert property (!ext_reset_pin_n_in [*3] |=> !sys_reset_n_out)
        else $error("pin request did not reset");
    flash_reset_a: assert property (flash_violation_in [*3] |=> !sys_reset_n_out)
        else $error("flash fault did not reset");
    reset_hold_a: assert property ($fell(sys_reset_n_out) |-> !sys_reset_n_out [*3])
        else $error("internal reset too short");
    // ------------------------------------------
    // clock switch and debug stall
    // ------------------------------------------
    gate_sel_a: assert property ($changed(sys_clk_sel_out) |-> !sys_clk_gate_out)
        else $error("source changed with gate open");
    // bound assumes the bench oscillator levels toggle within 16 cycles
    gate_back_a: assert property ($fell(sys_clk_gate_out) |-> ##[1:60] sys_clk_gate_out)
        else $error("clock switch never finished");
    stall_exempt_a: assert property ((periph_stall_out & periph_exempt_in) == '0)
        else $error("exempt peripheral stalled");
    halt_stall_a: assert property (debug_halt_in [*4] |-> periph_stall_out == ~periph_exempt_in)
        else $error("halt did not stall peripherals");
    stall_off_a: assert property (!debug_halt_in [*4] |-> periph_stall_out == '0)
        else $error("stall without halt");
    cover property ($fell(sys_reset_n_out));
    cover property ($rose(sys_clk_gate_out));
    cover property (debug_halt_in [*4]);
endmodule
`default_nettype wire

// file: crsc_test.sv
// self-checking bench for the clock and reset control block
`include "crsc_params.svh"
`timescale 1ns/100ps
`default_nettype none
module crsc_test;
    localparam int HOLD = 2;
    typedef struct packed {logic wr; logic [4:0] a; logic [7:0] d; logic [7:0] e;} crsc_row_s;
    // status reads after each switch carry {halt, busy, sel, gate}
    crsc_row_s rows [16] = '{
        '{1'b0, 5'h08, 8'h00, 8'h01}, '{1'b0, 5'h00, 8'h00, 8'h00}, '{1'b0, 5'h04, 8'h00, 8'h00},
        '{1'b0, 5'h18, 8'h00, 8'h00}, '{1'b0, 5'h1C, 8'h00, 8'h01}, '{1'b0, 5'h03, 8'h00, 8'h00},
        '{1'b1, 5'h04, 8'h39, 8'h00}, '{1'b0, 5'h1C, 8'h00, 8'h03}, '{1'b1, 5'h04, 8'h02, 8'h00},
        '{1'b0, 5'h1C, 8'h00, 8'h05}, '{1'b1, 5'h04, 8'h1F, 8'h00}, '{1'b0, 5'h1C, 8'h00, 8'h07},
        '{1'b1, 5'h04, 8'h20, 8'h00}, '{1'b1, 5'h08, 8'hFF, 8'h00}, '{1'b0, 5'h08, 8'h00, 8'h01},
        '{1'b0, 5'h04, 8'h00, 8'h20}};
    logic clk_in = 1'b0;
    logic reset_n_in = 1'b0;
    logic rd_en = 1'b0;
    logic wr_en = 1'b0;
    logic halt = 1'b0;
    logic [4:0] adr = 5'h00;
    logic [31:0] wdat = 32'h0;
    logic [8:0] req = 9'h000;
    logic [3:0] osc_ff = 4'h0;
    logic [7:0] exempt = 8'hA5;
    logic [31:0] rdat, rv;
    logic [7:0] stall;
    logic [1:0] sel;
    logic gate, msrc, men, usbm, rec, srst_n, irq, wreq;
    int fails = 0;
    int checks = 0;
    int n;
    logic seen;
    crsc_top #(.NUM_PERIPH(8), .HOLD_CYC(HOLD)) dut_u (
        .clk_in(clk_in), .reset_n_in(reset_n_in), .avs_address_in(adr), .avs_read_in(rd_en),
        .avs_write_in(wr_en), .avs_writedata_in(wdat), .avs_readdata_out(rdat), .avs_waitrequest_out(wreq),
        .supply_low_in(req[1]), .usb_bus_event_in(req[2]), .watchdog_timer_expired_in(req[3]),
        .missing_clock_in(req[4]), .comparator_level_in(req[5]), .ext_reset_pin_n_in(~req[7]),
        .flash_violation_in(req[8]), .hf_osc_level_in(osc_ff[0]), .lf_osc_level_in(osc_ff[1]),
        .ext_osc_level_in(osc_ff[2]), .mul_div2_level_in(osc_ff[3]), .debug_halt_in(halt),
        .periph_exempt_in(exempt), .periph_stall_out(stall), .sys_clk_sel_out(sel), .sys_clk_gate_out(gate),
        .mul_src_ext_out(msrc), .mul_enable_out(men), .usb_clk_from_mul_out(usbm),
        .clock_recovery_out(rec), .sys_reset_n_out(srst_n), .irq_out(irq));
    initial begin
        forever #2 clk_in = ~clk_in;
    end
    // free-running oscillator levels so the switch handshake always completes
    always @(posedge clk_in) osc_ff <= osc_ff + 4'h1;
    // ------------------------------------------
    // tasks
    // ------------------------------------------
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        checks++;
        if (got !== exp) begin
            fails++;
            $display("wrong value %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic bus(input logic wr, input logic [4:0] a, input logic [31:0] d);
        adr <= a;
        wdat <= d;
        wr_en <= wr;
        rd_en <= ~wr;
        do @(posedge clk_in); while (wreq !== 1'b0);
        rv = rdat;
        wr_en <= 1'b0;
        rd_en <= 1'b0;
        @(posedge clk_in);
    endtask
    task automatic wait_rst(input logic lvl, input int lim, output logic seen);
        seen = 1'b0;
        for (int i = 0; i < lim && !seen; i++) begin
            @(posedge clk_in);
            seen = (srst_n === lvl);
        end
    endtask
    task automatic fire(input int k, input logic e);
        logic s;
        if (k == 6) bus(1'b1, 5'h0C, 32'h1);
        else req[k] <= 1'b1;
        wait_rst(1'b0, 6, s);
        chk("reset taken", {31'h0, e}, {31'h0, s});
        repeat (8) @(posedge clk_in);
        if (k != 6) chk("reset held", {31'h0, ~e}, {31'h0, srst_n});
        req[k] <= 1'b0;
        wait_rst(1'b1, 30, s);
        chk("reset released", 32'h1, {31'h0, s});
    endtask
    task automatic end_sim;
        $display("checks %0d fails %0d", checks, fails);
        if (fails == 0 && checks > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask
    // ------------------------------------------
    // sequence
    // ------------------------------------------
    initial begin
        repeat (10) @(posedge clk_in);
        reset_n_in <= 1'b1;
        n = 0;
        do begin
            @(posedge clk_in);
            n++;
        end while (srst_n !== 1'b1 && n < 20);
        // outputs are sampled before each edge updates them, so the rise shows one edge later
        chk("reset stretch", HOLD + 2, n);
        foreach (rows[i]) begin
            bus(rows[i].wr, rows[i].a, {24'h0, rows[i].d});
            if (!rows[i].wr) chk("register", {24'h0, rows[i].e}, rv);
            if (rows[i].wr && rows[i].a == 5'h04) begin
                repeat (2) @(posedge clk_in);
                do bus(1'b0, 5'h1C, 32'h0); while (rv[3] !== 1'b0 || rv[0] !== 1'b1);
                chk("clock ports", {26'h0, rows[i].d[5:0]}, {rec, usbm, men, msrc, sel});
            end
        end
        $display("table done");
        fire(1, 1'b0);
        fire(8, 1'b1);
        bus(1'b0, 5'h08, 32'h0);
        chk("flash cause", 32'h1, rv[8]);
        fire(7, 1'b1);
        fire(6, 1'b0);
        bus(1'b1, 5'h00, 32'h7E);
        repeat (6) @(posedge clk_in);
        chk("no stale soft", 32'h1, {31'h0, srst_n});
        for (int k = 1; k < 7; k++) fire(k, 1'b1);
        bus(1'b1, 5'h00, 32'h200);
        bus(1'b1, 5'h00, 32'h0);
        fire(3, 1'b1);
        fire(2, 1'b0);
        $display("resets done");
        halt <= 1'b1;
        repeat (4) @(posedge clk_in);
        chk("stall", 32'h5A, stall);
        halt <= 1'b0;
        repeat (4) @(posedge clk_in);
        chk("stall off", 32'h0, stall);
        $display("halt done");
        bus(1'b1, 5'h18, 32'h0);
        chk("irq masked", 32'h0, irq);
        bus(1'b1, 5'h18, 32'h1);
        chk("irq raised", 32'h1, irq);
        bus(1'b1, 5'h14, 32'h3);
        chk("irq cleared", 32'h0, irq);
        bus(1'b0, 5'h10, 32'h0);
        chk("irq status", 32'h0, rv);
        $display("irq done");
        // a power-on reset in mid-run clears the sticky lock
        bus(1'b0, 5'h00, 32'h0);
        chk("lock kept", 32'h200, rv);
        reset_n_in <= 1'b0;
        repeat (3) @(posedge clk_in);
        reset_n_in <= 1'b1;
        wait_rst(1'b1, 20, seen);
        chk("por released", 32'h1, {31'h0, seen});
        bus(1'b0, 5'h00, 32'h0);
        chk("lock cleared", 32'h0, rv);
        bus(1'b0, 5'h08, 32'h0);
        chk("por cause", 32'h1, rv);
        $display("por done");
        end_sim();
    end
    initial begin
        #100000;
        fails++;
        end_sim();
    end
endmodule
bind crsc_top crsc_top_properties #(.NUM_PERIPH(NUM_PERIPH)) chk_u (.clk_in(clk_in), .reset_n_in(reset_n_in),
    .ext_reset_pin_n_in(ext_reset_pin_n_in), .flash_violation_in(flash_violation_in),
    .sys_reset_n_out(sys_reset_n_out), .debug_halt_in(debug_halt_in), .periph_exempt_in(periph_exempt_in),
    .periph_stall_out(periph_stall_out), .sys_clk_sel_out(sys_clk_sel_out), .sys_clk_gate_out(sys_clk_gate_out));
`default_nettype wire
